// file: dacs_pkg.sv
package dacs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // control word field positions
    localparam int unsigned PAIR_SEL_LSB    = 10;
    localparam int unsigned UPDATE_GATE_LSB = 8;
    localparam int unsigned DEEP_SLEEP_BIT  = 7;
    localparam int unsigned NAP_BIT         = 6;
    localparam int unsigned AUTO_DOZE_BIT   = 5;
    localparam int unsigned REF_OFF_BIT     = 4;
    localparam int unsigned ACCESS_LSB      = 0;

    // scan program word field positions
    localparam int unsigned HANDSHAKE_LSB   = 10;
    localparam int unsigned SCAN_LEN_LSB    = 8;
    localparam int unsigned SLOT1_LSB       = 6;
    localparam int unsigned SLOT2_LSB       = 4;
    localparam int unsigned SLOT3_LSB       = 2;
    localparam int unsigned POSITION_LSB    = 0;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [11:0] CTRL_WORD_RESET = 12'h000;
    localparam logic [11:0] SCAN_WORD_RESET = 12'h000;
    localparam logic [9:0]  REF_DAC_RESET   = 10'h3ff;

    // codes
    localparam logic [1:0]  GATE_ENABLE     = 2'h1;
    localparam logic [2:0]  ACC_DAC_WRITE   = 3'h1;
    localparam logic [2:0]  ACC_DAC_READ    = 3'h3;
    localparam logic [2:0]  ACC_SCAN_WRITE  = 3'h4;
    localparam logic [2:0]  ACC_SOFT_RESET  = 3'h5;
    localparam logic [2:0]  ACC_SCAN_READ   = 3'h6;
    localparam logic [1:0]  HS_ONE_TRIG     = 2'h2;
    localparam logic [1:0]  HS_ONE_BUSY     = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // cycle counts and result fifo depth
    localparam logic [3:0]  CONV_CLOCKS     = 4'hc;
    localparam logic [3:0]  WAKE_CLOCKS     = 4'h6;
    localparam logic [3:0]  GAP_CLOCKS      = 4'h2;
    localparam int unsigned RESULT_FIFO_DEPTH = 16;

    typedef enum logic [2:0] {
        CV_IDLE,
        CV_WAKE,
        CV_CONV,
        CV_PRE,
        CV_DRAIN,
        CV_GAP
    } dacs_conv_t;

    typedef enum logic [1:0] {
        RS_RESULT,
        RS_DAC,
        RS_SCAN
    } dacs_rsrc_t;

endpackage : dacs_pkg

// file: dacs_core.sv
`timescale 1ns/1ps
// Function
// - host writes control word, captured at strobe end
// - control word field layout, twelve bits
// - pair select codes drive input multiplexer
// - only update gate 01 enables programming
// - access function decodes next access
// - power-down applies at write strobe rise
// - DAC and sequencer need two writes
// - mux switches at write, trigger converts it
// - result register loads when busy falls
// - results two's complement twelve bits
// - third read without conversion returns zero
// - sequencer word layout, resets to zero
// - three handshake modes for trigger and busy
// - sequence length selects slots one to three
// - slot bits use pair select codes
// - position reads zero when disabled, else slot
// - results leave last in first out
// - surplus reads return zero
// - new conversion start overwrites unread results
// - read pointer resets on busy rise
// - twelve clocks plus precharge, no retrigger
// - access 101 soft resets whole device except the result fifo
// - reference DAC resets to all ones

////////////////////////////////////////////////////////////////////////////////
// result fifo between converter core and readout stack
module dacs_fifo #(
    parameter int unsigned WIDTH = 24,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk,       // system clock
    input  wire logic             reset,     // async reset, high
    input  wire logic [WIDTH-1:0] in_data,   // write data
    input  wire logic             in_valid,  // write request
    output logic                  in_ready,  // not full
    output logic [WIDTH-1:0]      out_data,  // head word
    output logic                  out_valid, // not empty
    input  wire logic             out_ready  // drain accepts head
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } dacs_fifo_st_t;

    dacs_fifo_st_t s_q;
    dacs_fifo_st_t s_d;
    logic          do_wr;
    logic          do_rd;

    assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = s_q.mem[s_q.rp];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    // pointer arithmetic wraps only for power-of-two depths
    always_comb begin
        s_d = s_q;
        if (do_wr) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp          = s_q.wp + 1'b1;
        end
        if (do_rd) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : dacs_fifo

////////////////////////////////////////////////////////////////////////////////
// control logic behind the parallel host port
module dacs_core (
    input  wire logic        clk,                   // 10 MHz system clock
    input  wire logic        reset,                 // async reset, high
    input  wire logic        wr_n,                  // write strobe, low active
    input  wire logic        rd_n,                  // read strobe, low active
    input  wire logic        conversion_trigger_n,  // falling edge starts
    input  wire logic [11:0] parallel_data_bus_in,  // bus level seen
    output logic      [11:0] parallel_data_bus_out, // read data driven
    output logic             parallel_data_bus_oe,  // high while driving
    output logic             busy,                  // conversion running
    input  wire logic [11:0] sample_a,              // converter A code
    input  wire logic [11:0] sample_b,              // converter B code
    output logic      [1:0]  mux_pair_sel,          // selected input pair
    output logic             deep_sleep,            // deep power-down
    output logic             nap,                   // nap power-down
    output logic             auto_doze,             // auto-nap enabled
    output logic             auto_doze_active,      // dozing after conversion
    output logic             reference_off,         // internal ref off
    output logic      [9:0]  ref_dac_code,          // reference DAC value
    output logic      [1:0]  scan_position          // next slot, 0 if off
);
    typedef struct packed {
        dacs_pkg::dacs_conv_t      st;
        dacs_pkg::dacs_rsrc_t      rsrc;
        logic [11:0]               cfg;
        logic [9:0]                dac;
        logic [9:0]                scan;     // bits 11:2 of scan word
        logic [1:0]                pos;
        logic                      pend_dac;
        logic                      pend_scan;
        logic                      wr_prev;
        logic                      rd_prev;
        logic                      trig_prev;
        logic [11:0]               wr_data;
        logic [3:0]                cnt;
        logic [1:0]                mux;
        logic [23:0]               hold;
        logic [2:0][23:0]          stack;
        logic [1:0]                depth;
        logic                      half;
        logic                      busy;
        logic [11:0]               dout;
        logic                      oe;
        logic                      doze;
    } dacs_state_t;

    localparam dacs_state_t RST = '{
        st: dacs_pkg::CV_IDLE, rsrc: dacs_pkg::RS_RESULT,
        cfg: dacs_pkg::CTRL_WORD_RESET, dac: dacs_pkg::REF_DAC_RESET,
        scan: dacs_pkg::SCAN_WORD_RESET[11:2], pos: 2'h0,
        wr_prev: 1'b1, rd_prev: 1'b1, trig_prev: 1'b1,
        default: '0};

    dacs_state_t s_q;
    dacs_state_t s_d;
    logic        wr_rise;
    logic        rd_fall;
    logic        trig_fall;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic [23:0] fifo_out_data;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [11:0] wdat;
    logic [2:0]  acc;
    logic [1:0]  len;
    logic [1:0]  hs;

    // slot code of a scan position; codes match the pair select
    function automatic logic [1:0] slot_sel(input logic [9:0] scan, input logic [1:0] pos);
        case (pos)
            2'h1:    slot_sel = scan[dacs_pkg::SLOT1_LSB-2 +: 2];
            2'h2:    slot_sel = scan[dacs_pkg::SLOT2_LSB-2 +: 2];
            2'h3:    slot_sel = scan[dacs_pkg::SLOT3_LSB-2 +: 2];
            default: slot_sel = 2'h0;
        endcase
    endfunction : slot_sel

    ////////////////////////////////////////////////////////////////////////////
    // strobe edges, inputs are synchronous
    assign wr_rise   = !s_q.wr_prev && wr_n;
    assign rd_fall   = s_q.rd_prev && !rd_n;
    assign trig_fall = s_q.trig_prev && !conversion_trigger_n;
    assign wdat      = s_q.wr_data;
    assign acc       = wdat[dacs_pkg::ACCESS_LSB +: 3];
    assign len       = s_q.scan[dacs_pkg::SCAN_LEN_LSB-2 +: 2];
    assign hs        = s_q.scan[dacs_pkg::HANDSHAKE_LSB-2 +: 2];

    // results stall in the fifo while a read pops the stack
    assign fifo_in_valid  = (s_q.st == dacs_pkg::CV_PRE);
    assign fifo_out_ready = !rd_fall;

    dacs_fifo #(
        .WIDTH (24),
        .DEPTH (dacs_pkg::RESULT_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_data   (s_q.hold),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [1:0] nxt;
        logic       last;
        s_d           = s_q;
        nxt           = 2'h0;
        last          = 1'b0;
        s_d.wr_prev   = wr_n;
        s_d.rd_prev   = rd_n;
        s_d.trig_prev = conversion_trigger_n;
        if (!wr_n) begin
            s_d.wr_data = parallel_data_bus_in;
        end

        // conversion sequencing
        case (s_q.st)
            dacs_pkg::CV_IDLE: begin
                // trigger during busy is the host's fault and is ignored
                if (trig_fall && fifo_in_ready) begin
                    s_d.doze = 1'b0;
                    s_d.cnt  = 4'h0;
                    s_d.st   = s_q.doze ? dacs_pkg::CV_WAKE : dacs_pkg::CV_CONV;
                    if (!s_q.doze) begin
                        s_d.hold  = {sample_a, sample_b};
                        s_d.busy  = 1'b1;
                        s_d.depth = 2'h0;
                        s_d.half  = 1'b0;
                    end
                end
            end
            dacs_pkg::CV_WAKE, dacs_pkg::CV_GAP: begin
                s_d.cnt = s_q.cnt + 4'h1;
                // the gap lets the newly switched pair settle before sampling
                if ((s_q.st == dacs_pkg::CV_GAP && s_q.cnt == dacs_pkg::GAP_CLOCKS - 4'h1) ||
                    (s_q.st == dacs_pkg::CV_WAKE && s_q.cnt == dacs_pkg::WAKE_CLOCKS - 4'h1)) begin
                    s_d.st    = dacs_pkg::CV_CONV;
                    s_d.cnt   = 4'h0;
                    s_d.hold  = {sample_a, sample_b};
                    s_d.busy  = 1'b1;
                    // one busy across all slots keeps the stack for lifo readout
                    if (!s_q.busy) begin
                        s_d.depth = 2'h0;
                        s_d.half  = 1'b0;
                    end
                end
            end
            dacs_pkg::CV_CONV: begin
                s_d.cnt = s_q.cnt + 4'h1;
                if (s_q.cnt == dacs_pkg::CONV_CLOCKS - 4'h1) begin
                    s_d.st = dacs_pkg::CV_PRE;
                end
            end
            dacs_pkg::CV_PRE: begin
                // precharge clock; holds until the fifo takes the pair
                if (fifo_in_ready) begin
                    s_d.st = dacs_pkg::CV_DRAIN;
                end
            end
            dacs_pkg::CV_DRAIN: begin
                // busy falls only once the pair sits in the stack
                if (!fifo_out_valid) begin
                    last = (len == 2'h0) || (s_q.pos == len);
                    nxt  = (len == 2'h0) ? 2'h0 : (last ? 2'h1 : s_q.pos + 2'h1);
                    s_d.pos = nxt;
                    if (len != 2'h0) begin
                        s_d.mux = slot_sel(s_q.scan, nxt);
                    end
                    s_d.cnt = 4'h0;
                    if (!last && hs == dacs_pkg::HS_ONE_BUSY) begin
                        // busy stays high through the settle gap
                        s_d.st   = dacs_pkg::CV_GAP;
                    end else if (!last && hs == dacs_pkg::HS_ONE_TRIG) begin
                        s_d.st   = dacs_pkg::CV_GAP;
                        s_d.busy = 1'b0;
                    end else begin
                        s_d.st   = dacs_pkg::CV_IDLE;
                        s_d.busy = 1'b0;
                        s_d.doze = s_q.cfg[dacs_pkg::AUTO_DOZE_BIT];
                    end
                end
            end
            default: begin
                s_d.st = dacs_pkg::CV_IDLE;
            end
        endcase

        // drained pair enters the stack, B below A so A leaves first
        if (fifo_out_valid && fifo_out_ready) begin
            if (s_d.depth == 2'h3) begin
                s_d.stack[2] = fifo_out_data;
            end else begin
                s_d.stack[s_d.depth] = fifo_out_data;
                s_d.depth            = s_d.depth + 2'h1;
            end
            s_d.half = 1'b0;
        end

        // read pulse: drive the chosen source while the strobe is low
        if (rd_fall) begin
            s_d.oe   = 1'b1;
            s_d.rsrc = dacs_pkg::RS_RESULT;
            case (s_q.rsrc)
                dacs_pkg::RS_DAC:  s_d.dout = {2'h0, s_q.dac};
                dacs_pkg::RS_SCAN: s_d.dout = {s_q.scan, s_q.pos};
                default: begin
                    if (s_q.depth == 2'h0) begin
                        s_d.dout = 12'h000;
                    end else if (!s_q.half) begin
                        s_d.dout = s_q.stack[s_q.depth - 2'h1][23:12];
                        s_d.half = 1'b1;
                    end else begin
                        s_d.dout  = s_q.stack[s_q.depth - 2'h1][11:0];
                        s_d.half  = 1'b0;
                        s_d.depth = s_q.depth - 2'h1;
                    end
                end
            endcase
        end else if (rd_n) begin
            s_d.oe = 1'b0;
        end

        // write strobe end: second write of a pair, or a control word
        if (wr_rise) begin
            if (s_q.pend_dac) begin
                s_d.dac      = wdat[9:0];
                s_d.pend_dac = 1'b0;
            end else if (s_q.pend_scan) begin
                s_d.scan      = wdat[11:2];
                s_d.pend_scan = 1'b0;
                s_d.pos       = (wdat[dacs_pkg::SCAN_LEN_LSB +: 2] == 2'h0) ? 2'h0 : 2'h1;
                s_d.mux       = (wdat[dacs_pkg::SCAN_LEN_LSB +: 2] == 2'h0)
                              ? s_q.cfg[dacs_pkg::PAIR_SEL_LSB +: 2]
                              : wdat[dacs_pkg::SLOT1_LSB +: 2];
            end else if (acc == dacs_pkg::ACC_SOFT_RESET) begin
                s_d = RST;
                s_d.wr_prev   = wr_n;
                s_d.rd_prev   = rd_n;
                s_d.trig_prev = conversion_trigger_n;
            end else begin
                s_d.cfg = wdat;
                if (len == 2'h0) begin
                    s_d.mux = wdat[dacs_pkg::PAIR_SEL_LSB +: 2];
                end
                // factory test gate 10 is treated as disabled
                if (wdat[dacs_pkg::UPDATE_GATE_LSB +: 2] == dacs_pkg::GATE_ENABLE) begin
                    s_d.pend_dac  = (acc == dacs_pkg::ACC_DAC_WRITE);
                    s_d.pend_scan = (acc == dacs_pkg::ACC_SCAN_WRITE);
                end
                if (acc == dacs_pkg::ACC_DAC_READ) begin
                    s_d.rsrc = dacs_pkg::RS_DAC;
                end else if (acc == dacs_pkg::ACC_SCAN_READ) begin
                    s_d.rsrc = dacs_pkg::RS_SCAN;
                end
                // deep or nap abort a running conversion
                if (wdat[dacs_pkg::DEEP_SLEEP_BIT] || wdat[dacs_pkg::NAP_BIT]) begin
                    s_d.st   = dacs_pkg::CV_IDLE;
                    s_d.busy = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from state flops
    assign parallel_data_bus_out = s_q.dout;
    assign parallel_data_bus_oe  = s_q.oe;
    assign busy                  = s_q.busy;
    assign mux_pair_sel          = s_q.mux;
    assign deep_sleep            = s_q.cfg[dacs_pkg::DEEP_SLEEP_BIT];
    assign nap                   = s_q.cfg[dacs_pkg::NAP_BIT];
    assign auto_doze             = s_q.cfg[dacs_pkg::AUTO_DOZE_BIT];
    assign auto_doze_active      = s_q.doze;
    assign reference_off         = s_q.cfg[dacs_pkg::REF_OFF_BIT];
    assign ref_dac_code          = s_q.dac;
    assign scan_position         = s_q.pos;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_ctrl_write;
        wr_rise && !s_q.pend_dac && !s_q.pend_scan && acc != dacs_pkg::ACC_SOFT_RESET;
    endsequence

    sequence s_start;
        s_q.st == dacs_pkg::CV_IDLE && trig_fall && fifo_in_ready && !s_q.doze;
    endsequence

    sequence s_conv_body;
        ##11 (s_q.st == dacs_pkg::CV_CONV) ##1 (s_q.st == dacs_pkg::CV_PRE);
    endsequence

    AST_CTRL_CAPTURE: assert property (s_ctrl_write |=> s_q.cfg == $past(wdat))
        else $error("control word not captured");
    AST_DAC_SECOND: assert property (wr_rise && s_q.pend_dac |=>
        ref_dac_code == $past(wdat[9:0]) && !s_q.pend_dac)
        else $error("dac second write not applied");
    AST_GATE_OFF: assert property ((s_ctrl_write
        and (wdat[dacs_pkg::UPDATE_GATE_LSB +: 2] != dacs_pkg::GATE_ENABLE))
        |=> !s_q.pend_dac && !s_q.pend_scan)
        else $error("programming armed with gate closed");
    AST_SOFT_RESET: assert property (wr_rise && !s_q.pend_dac && !s_q.pend_scan
        && acc == dacs_pkg::ACC_SOFT_RESET
        |=> s_q.cfg == 12'h000 && ref_dac_code == 10'h3ff && !busy)
        else $error("soft reset incomplete");
    AST_CONV_TIME: assert property (s_start |=> busy ##0 s_conv_body)
        else $error("conversion length wrong");
    AST_POS_OFF: assert property (len == 2'h0 |-> scan_position == 2'h0)
        else $error("position not zero while disabled");
    AST_EMPTY_READ: assert property (rd_fall && s_q.rsrc == dacs_pkg::RS_RESULT
        && s_q.depth == 2'h0 |=> parallel_data_bus_out == 12'h000 && parallel_data_bus_oe)
        else $error("surplus read not zero");
    AST_LIFO_A_FIRST: assert property (rd_fall && s_q.rsrc == dacs_pkg::RS_RESULT
        && s_q.depth != 2'h0 && !s_q.half
        |=> parallel_data_bus_out == $past(s_q.stack[s_q.depth - 2'h1][23:12]))
        else $error("lifo order wrong");
    AST_BUSY_RISE_CLEAR: assert property ($rose(busy) |-> s_q.depth == 2'h0)
        else $error("read pointer not reset");
    AST_POS_WRAP: assert property (s_q.st == dacs_pkg::CV_DRAIN && !fifo_out_valid
        && len != 2'h0 && s_q.pos == len |=> scan_position == 2'h1)
        else $error("position did not return to slot one");
    AST_PD_AT_WR: assert property ((s_ctrl_write and wdat[dacs_pkg::DEEP_SLEEP_BIT])
        |=> deep_sleep && !busy)
        else $error("deep sleep not applied at write");
endmodule : dacs_core

// file: dacs_host.sv
`timescale 1ns/1ps
// host side of the parallel port: strobes, data and bus level
module dacs_host (
    input  wire logic        clk,     // system clock
    input  wire logic [11:0] dev_out, // device read data
    input  wire logic        dev_oe,  // device drives bus
    output logic             wr_n,    // write strobe
    output logic             rd_n,    // read strobe
    output logic      [11:0] bus      // resolved bus level
);
    logic        drv;
    logic [11:0] hd;
    logic [11:0] last;
    initial begin
        wr_n = 1'b1;
        rd_n = 1'b1;
        drv  = 1'b0;
        hd   = 12'h000;
        last = 12'h000;
    end
    // released bus floats: show inverse of the last level, never a kind value
    always_comb bus = dev_oe ? dev_out : (drv ? hd : ~last);
    always @(posedge clk) if (dev_oe | drv) last <= bus;
    // data held until the edge that samples the strobe rise
    task automatic wr(input logic [11:0] d);
        @(posedge clk);
        wr_n <= 1'b0;
        drv  <= 1'b1;
        hd   <= d;
        @(posedge clk);
        wr_n <= 1'b1;
        @(posedge clk);
        drv  <= 1'b0;
        @(posedge clk);
    endtask : wr
    // one read pulse, two cycles low
    task automatic rd;
        @(posedge clk);
        rd_n <= 1'b0;
        repeat (2) @(posedge clk);
        rd_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : rd
endmodule : dacs_host

// file: dual_adc_config_sequencer_test.sv
`timescale 1ns/1ps
module dual_adc_config_sequencer_test;
    logic        clk;
    logic        reset;
    logic        trig_n;
    logic [11:0] sa;
    logic [11:0] sb;
    logic [11:0] base = 12'h000;
    logic [31:0] rnd = 32'h7ecc8a2b;
    logic [11:0] exp_q[$];
    logic [11:0] dout, bus;
    logic [9:0]  dac;
    logic [1:0]  mux, pos;
    logic        oe, busy, ds, np, ad, ada, roff, wr_n, rd_n;
    logic        oe_q = 1'b0;
    int          bad_count = 0;
    int          cmp_count = 0;
    always #50 clk = ~clk;
    dacs_host i_dacs_host (.clk(clk), .dev_out(dout), .dev_oe(oe), .wr_n(wr_n), .rd_n(rd_n),
        .bus(bus));
    dacs_core i_dacs_core (.clk(clk), .reset(reset), .wr_n(wr_n), .rd_n(rd_n),
        .conversion_trigger_n(trig_n), .parallel_data_bus_in(bus),
        .parallel_data_bus_out(dout), .parallel_data_bus_oe(oe), .busy(busy),
        .sample_a(sa), .sample_b(sb), .mux_pair_sel(mux), .deep_sleep(ds), .nap(np),
        .auto_doze(ad), .auto_doze_active(ada), .reference_off(roff),
        .ref_dac_code(dac), .scan_position(pos));
    function automatic logic [11:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd[11:0];
    endfunction : xs
    task automatic close_out;
        if (bad_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [11:0] got, input logic [11:0] want);
        cmp_count++;
        if (got !== want) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h want=%h", $time, got, want);
        end
    endtask : chk
    task automatic rdx(input logic [11:0] e);
        exp_q.push_back(e);
        i_dacs_host.rd();
    endtask : rdx
    // one trigger pulse, then a bounded wait for busy to drop
    task automatic conv;
        int n = 0;
        @(posedge clk);
        base <= xs();
        @(posedge clk);
        trig_n <= 1'b0;
        @(posedge clk);
        trig_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk({11'h000, busy}, 12'h001);
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (busy !== 1'b0) begin
            bad_count++;
            close_out();
        end else begin
            repeat (2) @(posedge clk);
        end
    endtask : conv
    // converter stand-in: low bits carry the pair, so lifo order is visible
    always @(posedge clk) begin
        sa <= {base[11:2], mux};
        sb <= {~base[11:2], mux};
    end
    // read watcher: oldest note against each fresh bus drive
    always @(posedge clk) begin
        oe_q <= oe;
        if (oe && !oe_q) chk(dout, exp_q.size() ? exp_q.pop_front() : 12'hxxx);
    end
    initial begin
        clk    = 1'b0;
        reset  = 1'b1;
        trig_n = 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk({dac, pos}, 12'hffc);
        i_dacs_host.wr(12'h910);
        chk({8'h00, mux, ds, np, ad, roff}, 12'h021);
        i_dacs_host.wr(12'h101);
        i_dacs_host.wr(12'h0cd);
        chk({2'h0, dac}, 12'h0cd);
        i_dacs_host.wr(12'hb01);
        i_dacs_host.wr(12'h912);
        chk({dac, 1'b0, roff}, 12'h335);
        i_dacs_host.wr(12'h913);
        rdx(12'h0cd);
        conv();
        rdx({base[11:2], 2'h2});
        rdx({~base[11:2], 2'h2});
        rdx(12'h000);
        i_dacs_host.wr(12'h914);
        i_dacs_host.wr(12'hf6e);
        chk({10'h000, pos}, 12'h001);
        i_dacs_host.wr(12'h916);
        rdx(12'hf6d);
        conv();
        for (int k = 3; k > 0; k--) begin
            rdx({base[11:2], k[1:0]});
            rdx({~base[11:2], k[1:0]});
        end
        rdx(12'h000);
        chk({10'h000, pos}, 12'h001);
        i_dacs_host.wr(12'h105);
        repeat (2) @(posedge clk);
        chk({dac, pos}, 12'hffc);
        i_dacs_host.wr(12'h1e0);
        chk({8'h00, mux, ds, np, ad, roff}, 12'h00e);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk({8'h00, mux, ds, np, ad, roff}, 12'h000);
        close_out();
    end
endmodule : dual_adc_config_sequencer_test
